// >>> logic/scpi_message_parser.sv
// Character-stream parser for program messages with a keyword tree.
// What this block does
// - Short form: whole word up to four letters, else four, three if fourth is vowel.
// - Any spelling other than exact short or full long form is an error.
// - Keyword letters compare without regard to case.
// - A colon between keywords moves the tree position one level deeper.
// - A question mark after the last keyword marks the unit a query.
// - Parameters follow the last keyword after a space.
// - Semicolons split message units.
// - A colon before a unit's first keyword returns the position to root.
// - Only newline 0A hex ends a message.
// - The terminator returns the tree position to root.
// - Optional source level may be omitted; its children resolve at root.
// - Root branches and source children are recognised as listed.
// - After a bare semicolon the next keyword resolves at the previous level.
// - A keyword missing at the current level raises an error.
// - A unit starting with an asterisk is a common command, tree untouched.
// - Status bit 3 stays zero on clean decode, set after an error.
// - Status bit 4 is set while query response data waits.
// - Status bit 3 stays high while the error queue is not empty.
`timescale 1ns/100ps
module scpi_message_parser #(
	parameter int ERR_W = 4
) (
	// Clock and reset
	input  wire logic           ref_clk,
	input  wire logic           sys_rst,
	// Character stream from the host
	input  wire logic           charValid,
	input  wire logic [7:0]     charData,
	output logic                charReady,
	// Resolved message units
	output logic                unitValid,
	input  wire logic           unitReady,
	output scpi_pkg::unit_t     unitInfo,
	// Status byte and its clearing strobes
	input  wire logic           errPop,
	input  wire logic           respTaken,
	output logic [7:0]          statusByte
);
	if (ERR_W < 1 || ERR_W > 16) begin : g_chk
		$error("scpi_message_parser error counter width out of range");
	end

	scpi_pkg::parse_state_t state, next_state;
	scpi_pkg::word_t        word, next_word;
	scpi_pkg::len_t         len, next_len;
	scpi_pkg::node_t        level, next_level;
	scpi_pkg::unit_t        cur, next_cur, pushData;
	logic [ERR_W-1:0]       errCount, next_errCount;
	logic                   respPending, next_respPending;
	logic [7:0]             next_statusByte;
	logic                   accepted, push, raise, bufReady;
	logic                   isLetter, hit, errInc, errDec;
	logic [7:0]             upper;
	scpi_pkg::node_t        hitNode;

	// A character is taken only while the buffer can hold a unit, so no result is lost.
	assign charReady = bufReady;
	assign accepted  = charValid && charReady;

	// Letters are folded to upper case before they enter the word.
	assign isLetter = (charData >= scpi_pkg::CH_UP_A && charData <= scpi_pkg::CH_UP_Z) ||
		(charData >= scpi_pkg::CH_LOW_A && charData <= scpi_pkg::CH_LOW_Z);
	assign upper = charData & scpi_pkg::CASE_MASK;

	// The matcher sees the collected word at the present tree level.
	keyword_matcher u_match (
		.word  (word),
		.len   (len),
		.level (level),
		.hit   (hit),
		.node  (hitNode)
	);

	// Parser next state; every result and every error is decided here.
	always_comb begin
		next_state = state;
		next_word = word;
		next_len = len;
		next_level = level;
		next_cur = cur;
		push = 1'b0;
		raise = 1'b0;
		if (accepted) begin
			case (state)
				scpi_pkg::ST_START: begin
					next_cur = '0;
					next_word = '0;
					next_len = 4'h0;
					if (charData == scpi_pkg::CH_LF) begin
						next_level = scpi_pkg::ROOT_NODE;
					end else if (charData == scpi_pkg::CH_COLON) begin
						next_level = scpi_pkg::ROOT_NODE;
						next_state = scpi_pkg::ST_WORD;
					end else if (charData == scpi_pkg::CH_STAR) begin
						next_cur.common = 1'b1;
						next_state = scpi_pkg::ST_COMMON;
					end else if (isLetter) begin
						next_word = {88'h0, upper};
						next_len = 4'h1;
						next_state = scpi_pkg::ST_WORD;
					end else if (charData != scpi_pkg::CH_SPACE) begin
						raise = 1'b1;
					end
				end
				scpi_pkg::ST_WORD: begin
					if (isLetter && len != scpi_pkg::MAX_LEN) begin
						next_word = {word[87:0], upper};
						next_len = len + 4'h1;
					end else if (!hit || len == 4'h0) begin
						raise = 1'b1;
					end else begin
						next_cur.node = hitNode;
						next_word = '0;
						next_len = 4'h0;
						case (charData)
							scpi_pkg::CH_COLON: begin
								next_level = hitNode;
							end
							scpi_pkg::CH_QUERY: begin
								next_cur.query = 1'b1;
								next_state = scpi_pkg::ST_DATA;
							end
							scpi_pkg::CH_SPACE: begin
								next_state = scpi_pkg::ST_DATA;
							end
							scpi_pkg::CH_SEMI: begin
								push = 1'b1;
								next_state = scpi_pkg::ST_START;
							end
							scpi_pkg::CH_LF: begin
								push = 1'b1;
								next_level = scpi_pkg::ROOT_NODE;
								next_state = scpi_pkg::ST_START;
							end
							default: begin
								raise = 1'b1;
							end
						endcase
					end
				end
				scpi_pkg::ST_DATA, scpi_pkg::ST_COMMON: begin
					if (charData == scpi_pkg::CH_SEMI) begin
						push = 1'b1;
						next_state = scpi_pkg::ST_START;
					end else if (charData == scpi_pkg::CH_LF) begin
						push = 1'b1;
						next_level = scpi_pkg::ROOT_NODE;
						next_state = scpi_pkg::ST_START;
					end else if (charData != scpi_pkg::CH_SPACE) begin
						next_cur.hasData = 1'b1;
					end
				end
				scpi_pkg::ST_DISCARD: begin
					if (charData == scpi_pkg::CH_LF) begin
						next_level = scpi_pkg::ROOT_NODE;
						next_state = scpi_pkg::ST_START;
					end
				end
				default: begin
					next_state = scpi_pkg::ST_START;
				end
			endcase
			// An error reports once, then the rest of the message is dropped.
			if (raise) begin
				push = 1'b1;
				next_word = '0;
				next_len = 4'h0;
				if (charData == scpi_pkg::CH_LF) begin
					next_level = scpi_pkg::ROOT_NODE;
					next_state = scpi_pkg::ST_START;
				end else begin
					next_state = scpi_pkg::ST_DISCARD;
				end
			end
		end
		pushData = next_cur;
		pushData.error = raise;
	end

	// Parser registers.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= scpi_pkg::ST_START;
			word <= '0;
			len <= 4'h0;
			level <= scpi_pkg::ROOT_NODE;
			cur <= '0;
		end else begin
			state <= next_state;
			word <= next_word;
			len <= next_len;
			level <= next_level;
			cur <= next_cur;
		end
	end

	// Results wait here until the consumer takes them.
	unit_buffer #(
		.WIDTH ($bits(scpi_pkg::unit_t))
	) u_buf (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.inValid  (push),
		.inReady  (bufReady),
		.inData   (pushData),
		.outValid (unitValid),
		.outReady (unitReady),
		.outData  (unitInfo)
	);

	// Error queue depth and response flag; a new event beats a clear in the same cycle, except a new error on a saturated counter.
	// The counter saturates, so a flood of errors is undercounted but never wraps to empty.
	always_comb begin
		errInc = push && pushData.error && (errCount != {ERR_W{1'b1}});
		errDec = errPop && (errCount != '0) && !errInc;
		next_errCount = errCount;
		if (errInc) begin
			next_errCount = errCount + 1'b1;
		end else if (errDec) begin
			next_errCount = errCount - 1'b1;
		end
		next_respPending = respPending;
		if (respTaken) begin
			next_respPending = 1'b0;
		end
		if (push && pushData.query && !pushData.error) begin
			next_respPending = 1'b1;
		end
		next_statusByte = 8'h00;
		next_statusByte[scpi_pkg::ERR_BIT] = (next_errCount != '0);
		next_statusByte[scpi_pkg::RESP_BIT] = next_respPending;
	end

	// Status registers.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			errCount <= '0;
			respPending <= 1'b0;
			statusByte <= 8'h00;
		end else begin
			errCount <= next_errCount;
			respPending <= next_respPending;
			statusByte <= next_statusByte;
		end
	end

	// Checks on the parser's own behaviour.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	root_on_lf_a: assert property (
		accepted && charData == scpi_pkg::CH_LF |=> level == scpi_pkg::ROOT_NODE)
		else $error("tree position not at root after terminator");

	root_colon_a: assert property (
		accepted && state == scpi_pkg::ST_START && charData == scpi_pkg::CH_COLON
		|=> level == scpi_pkg::ROOT_NODE && state == scpi_pkg::ST_WORD)
		else $error("root specifier did not reset position");

	colon_descend_a: assert property (
		accepted && state == scpi_pkg::ST_WORD && hit && len != 4'h0 &&
		charData == scpi_pkg::CH_COLON |=> level == $past(hitNode))
		else $error("separator did not descend beneath keyword");

	semi_level_a: assert property (
		accepted && state == scpi_pkg::ST_WORD && hit && len != 4'h0 &&
		charData == scpi_pkg::CH_SEMI |=> level == $past(level) && state == scpi_pkg::ST_START)
		else $error("semicolon changed the tree position");

	query_mark_a: assert property (
		accepted && state == scpi_pkg::ST_WORD && hit && len != 4'h0 &&
		charData == scpi_pkg::CH_QUERY |=> cur.query && state == scpi_pkg::ST_DATA)
		else $error("query mark not recorded");

	case_fold_a: assert property (
		accepted && state == scpi_pkg::ST_WORD && isLetter && len != scpi_pkg::MAX_LEN
		|=> word[7:0] == ($past(charData) & scpi_pkg::CASE_MASK) && len == $past(len) + 4'h1)
		else $error("letter not folded into word");

	bad_word_a: assert property (
		accepted && state == scpi_pkg::ST_WORD && !hit && !isLetter
		|-> push && pushData.error ##1 state != scpi_pkg::ST_WORD)
		else $error("unknown keyword not reported");

	discard_hold_a: assert property (
		state == scpi_pkg::ST_DISCARD && accepted && charData != scpi_pkg::CH_LF
		|-> !push ##1 state == scpi_pkg::ST_DISCARD)
		else $error("discarding left before terminator");

	err_status_a: assert property (
		push && pushData.error && charReady |=> statusByte[scpi_pkg::ERR_BIT] && errCount != '0)
		else $error("error did not raise status bit 3");

	resp_status_a: assert property (
		push && pushData.query && !pushData.error |=> statusByte[scpi_pkg::RESP_BIT])
		else $error("query did not raise status bit 4");

	common_unit_a: assert property (
		accepted && state == scpi_pkg::ST_START && charData == scpi_pkg::CH_STAR
		|=> state == scpi_pkg::ST_COMMON && cur.common && level == $past(level))
		else $error("asterisk unit not taken as common command");

	push_taken_a: assert property (
		push |-> charValid && charReady ##1 unitValid)
		else $error("result produced without an accepted character");

endmodule

// >>> logic/scpi_pkg.sv
// Shared constants, keyword tree and types for the message parser.
package scpi_pkg;

	// Character codes seen by the parser.
	localparam logic [7:0] CH_LF     = 8'h0A;
	localparam logic [7:0] CH_SPACE  = 8'h20;
	localparam logic [7:0] CH_STAR   = 8'h2A;
	localparam logic [7:0] CH_COLON  = 8'h3A;
	localparam logic [7:0] CH_SEMI   = 8'h3B;
	localparam logic [7:0] CH_QUERY  = 8'h3F;
	localparam logic [7:0] CH_UP_A   = 8'h41;
	localparam logic [7:0] CH_UP_Z   = 8'h5A;
	localparam logic [7:0] CH_LOW_A  = 8'h61;
	localparam logic [7:0] CH_LOW_Z  = 8'h7A;
	localparam logic [7:0] CASE_MASK = 8'hDF;

	// Keyword geometry and tree positions.
	localparam int NUM_KW = 25;
	localparam logic [3:0] MAX_LEN = 4'hC;
	localparam logic [3:0] SHORT_MAX = 4'h4;
	localparam logic [3:0] VOWEL_SHORT = 4'h3;
	localparam logic [4:0] ROOT_NODE = 5'h00;
	localparam logic [4:0] OPT_NODE = 5'h08;

	// Status byte bit positions.
	localparam int ERR_BIT = 3;
	localparam int RESP_BIT = 4;

	typedef logic [4:0] node_t;
	typedef logic [3:0] len_t;
	typedef logic [95:0] word_t;

	// Long forms, right aligned, last letter in the low byte; node id is index plus one.
	localparam word_t KW_NAME [NUM_KW] = '{
		"ABORT", "CALIBRATE", "DISPLAY", "INITIATE", "LIST", "MEASURE", "OUTPUT",
		"SOURCE", "STATUS", "SYSTEM", "TRIGGER", "VOLTAGE", "CURRENT", "FUNCTION",
		"OPERATION", "PRESET", "QUESTIONABLE", "VOLTAGE", "CURRENT", "CONDITION",
		"ENABLE", "EVENT", "LEVEL", "LEVEL", "ERROR"};
	localparam len_t KW_LEN [NUM_KW] = '{
		4'h5, 4'h9, 4'h7, 4'h8, 4'h4, 4'h7, 4'h6, 4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7,
		4'h8, 4'h9, 4'h6, 4'hC, 4'h7, 4'h7, 4'h9, 4'h6, 4'h5, 4'h5, 4'h5, 4'h5};
	localparam node_t KW_PARENT [NUM_KW] = '{
		5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
		5'h08, 5'h08, 5'h08, 5'h09, 5'h09, 5'h09, 5'h06, 5'h06, 5'h0F, 5'h0F, 5'h0F,
		5'h0C, 5'h0D, 5'h0A};

	// One finished message unit.
	typedef struct packed {
		node_t node;
		logic  query;
		logic  common;
		logic  hasData;
		logic  error;
	} unit_t;

	typedef enum logic [2:0] {
		ST_START   = 3'h0,
		ST_WORD    = 3'h1,
		ST_DATA    = 3'h3,
		ST_COMMON  = 3'h2,
		ST_DISCARD = 3'h6
	} parse_state_t;

	// Upper-case vowel test used to derive short forms.
	function automatic logic is_vowel(input logic [7:0] c);
		return (c == 8'h41) || (c == 8'h45) || (c == 8'h49) || (c == 8'h4F) || (c == 8'h55);
	endfunction

endpackage

// >>> logic/unit_buffer.sv
// Two-entry buffer between the parser and the unit consumer.
`timescale 1ns/100ps
module unit_buffer #(
	parameter int WIDTH = 9
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	// Filling side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	if (WIDTH < 1) begin : g_chk
		$error("unit_buffer width must be positive");
	end

	logic [WIDTH-1:0] mem [2];
	logic [WIDTH-1:0] next_mem [2];
	logic             wrPtr, rdPtr, next_wrPtr, next_rdPtr;
	logic [1:0]       count, next_count;
	logic             doWr, doRd;

	// Full and empty come straight from the occupancy count.
	assign inReady  = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign outData  = mem[rdPtr];
	assign doWr     = inValid && inReady;
	assign doRd     = outValid && outReady;

	// Next pointers, count and storage.
	always_comb begin
		next_mem = mem;
		next_wrPtr = wrPtr;
		next_rdPtr = rdPtr;
		next_count = count;
		if (doWr) begin
			next_mem[wrPtr] = inData;
			next_wrPtr = !wrPtr;
		end
		if (doRd) begin
			next_rdPtr = !rdPtr;
		end
		if (doWr && !doRd) begin
			next_count = count + 2'h1;
		end else if (doRd && !doWr) begin
			next_count = count - 2'h1;
		end
	end

	// Register stage.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mem[0] <= '0;
			mem[1] <= '0;
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			count <= 2'h0;
		end else begin
			mem <= next_mem;
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
		end
	end
endmodule

// >>> logic/keyword_matcher.sv
// Resolves a collected keyword against the command tree at one level.
`timescale 1ns/100ps
module keyword_matcher (
	// Keyword and position
	input  wire scpi_pkg::word_t word,
	input  wire scpi_pkg::len_t  len,
	input  wire scpi_pkg::node_t level,
	// Result
	output logic                 hit,
	output scpi_pkg::node_t      node
);
	logic [scpi_pkg::NUM_KW-1:0] match;

	// One comparator per tree entry; short form derived from the long form.
	for (genvar k = 0; k < scpi_pkg::NUM_KW; k++) begin : g_kw
		localparam scpi_pkg::len_t LL = scpi_pkg::KW_LEN[k];
		localparam logic [7:0] FOURTH = scpi_pkg::KW_NAME[k][8 * (int'(LL) - 4) +: 8];
		localparam scpi_pkg::len_t SL = (LL <= scpi_pkg::SHORT_MAX) ? LL :
			(scpi_pkg::is_vowel(FOURTH) ? scpi_pkg::VOWEL_SHORT : scpi_pkg::SHORT_MAX);
		localparam scpi_pkg::word_t SN = scpi_pkg::KW_NAME[k] >> (8 * (int'(LL) - int'(SL)));
		logic here;
		// Children of the optional level also resolve at the root.
		assign here = (scpi_pkg::KW_PARENT[k] == level) ||
			(scpi_pkg::KW_PARENT[k] == scpi_pkg::OPT_NODE && level == scpi_pkg::ROOT_NODE);
		// Only the exact short or the whole long spelling counts.
		assign match[k] = here && ((len == LL && word == scpi_pkg::KW_NAME[k]) ||
			(len == SL && word == SN));
	end

	// Lowest entry wins; the tree keeps names unique per level.
	always_comb begin
		hit = 1'b0;
		node = scpi_pkg::ROOT_NODE;
		for (int k = scpi_pkg::NUM_KW - 1; k >= 0; k--) begin
			if (match[k]) begin
				hit = 1'b1;
				node = 5'(k + 1);
			end
		end
	end
endmodule

// >>> tb/host_sender.sv
// Host controller model that streams program message characters into the parser.
`timescale 1ns/100ps
module host_sender (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Character stream towards the parser
	output logic       charValid,
	output logic [7:0] charData,
	input  wire logic  charReady
);
	// Idle line at time zero.
	initial begin
		charValid = 1'b0;
		charData  = 8'h00;
	end

	// Sends one message; gap idle cycles after each character model a slow host.
	// A released data line shows the inverse of its last value so nothing stale looks valid.
	task automatic send(input string body, input int gap);
		string msg;
		msg = {body, "\n"};
		// Nothing is offered while the parser is held in reset.
		while (sys_rst !== 1'b0) begin
			@(posedge ref_clk);
			#1;
		end
		foreach (msg[i]) begin
			charData  = msg[i];
			charValid = 1'b1;
			do @(posedge ref_clk); while (charReady !== 1'b1);
			#1;
			if (gap > 0) begin
				charValid = 1'b0;
				charData  = ~msg[i];
				repeat (gap) @(posedge ref_clk);
				#1;
			end
		end
		// Only a line still driven is inverted; after a gap it already shows the inverse.
		if (charValid) begin
			charData = ~charData;
		end
		charValid = 1'b0;
	endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the message parser with a host model on its input.
`timescale 1ns/100ps
module testbench;
	logic            ref_clk = 1'b0;
	logic            sys_rst;
	logic            charValid;
	logic [7:0]      charData;
	logic            charReady;
	logic            unitValid;
	logic            unitReady = 1'b0;
	scpi_pkg::unit_t unitInfo;
	logic            errPop;
	logic            respTaken;
	logic [7:0]      statusByte;
	logic [7:0]      rnd = 8'h53;
	logic [7:0]      seed;
	bit              holdOff;
	bit              sawFull = 1'b0;
	int              errors;
	int              samples_checked;
	logic [8:0]      got[$];
	logic [8:0]      expU[$];
	logic [8:0]      expM[$];
	localparam logic [8:0] FULL = 9'h1FF;
	localparam logic [8:0] ERRM = 9'h001;
	localparam logic [8:0] COMM = 9'h1F4;

	scpi_message_parser #(.ERR_W(4)) dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .charValid(charValid), .charData(charData),
		.charReady(charReady), .unitValid(unitValid), .unitReady(unitReady),
		.unitInfo(unitInfo), .errPop(errPop), .respTaken(respTaken), .statusByte(statusByte)
	);
	host_sender host (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .charValid(charValid), .charData(charData),
		.charReady(charReady)
	);

	// Free running clock, 20 ns period.
	always #10 ref_clk = ~ref_clk;

	function automatic logic [7:0] lfsr(input logic [7:0] r);
		return {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
	endfunction

	// Short form length: whole word up to four letters, else four, three on a fourth vowel.
	function automatic int short_len(input int idx);
		int         len;
		logic [7:0] c;
		len = int'(scpi_pkg::KW_LEN[idx]);
		if (len <= 4) return len;
		c = scpi_pkg::KW_NAME[idx][8*(len-4) +: 8];
		return (c == "A" || c == "E" || c == "I" || c == "O" || c == "U") ? 3 : 4;
	endfunction

	// First cnt letters of a keyword, each lowered where its flip bit is set.
	function automatic string spell(input int idx, input int cnt, input logic [7:0] flip);
		string      s;
		int         len;
		logic [7:0] c;
		s   = "";
		len = int'(scpi_pkg::KW_LEN[idx]);
		for (int k = 0; k < cnt; k++) begin
			c = scpi_pkg::KW_NAME[idx][8*(len-1-k) +: 8];
			if (flip[k%8]) c = c | 8'h20;
			s = {s, "x"};
			s.putc(k, c);
		end
		return s;
	endfunction

	// Random consumer; holdOff forces a long stall to fill the result buffer.
	always @(posedge ref_clk) begin
		#1;
		rnd       = lfsr(rnd);
		unitReady = !holdOff && (rnd[1:0] != 2'b00);
	end

	// Results are collected on the edge that takes them; refusals during a stall are noted.
	always @(posedge ref_clk) begin
		if (sys_rst === 1'b0 && unitValid === 1'b1 && unitReady === 1'b1) got.push_back(unitInfo);
		if (holdOff && charReady === 1'b0) sawFull = 1'b1;
	end

	task automatic check(input string what, input logic [8:0] e, input logic [8:0] s);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic ex(input logic [4:0] n, input logic [3:0] f, input logic [8:0] m);
		expU.push_back({n, f});
		expM.push_back(m);
	endtask

	// Sends one message at a random pace and compares every unit it produced.
	task automatic run(input string body, input string name);
		int n;
		got.delete();
		seed = lfsr(seed);
		host.send(body, int'(seed[7:6]));
		n = 0;
		while (got.size() < expU.size() && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (4) @(posedge ref_clk);
		#1;
		check({name, " count"}, 9'(expU.size()), 9'(got.size()));
		foreach (expU[i]) if (i < got.size()) check(name, expU[i] & expM[i], got[i] & expM[i]);
		expU.delete();
		expM.delete();
		$display("test %s done", name);
	endtask

	// Removes one error entry and waits for the status byte to follow.
	task automatic pop_err();
		errPop = 1'b1;
		@(posedge ref_clk);
		#1;
		errPop = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		int k;
		sys_rst   = 1'b1;
		errPop    = 1'b0;
		respTaken = 1'b0;
		holdOff   = 1'b0;
		seed      = 8'h53;
		repeat (20) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		check("reset outputs", 9'h100, {charReady, statusByte});
		for (int i = 0; i < 14; i++) begin
			ex(5'(i + 1), 4'h8, FULL);
			run({spell(i, short_len(i), seed), "?"}, "short query");
			ex(5'(i + 1), 4'h0, FULL);
			run(spell(i, int'(scpi_pkg::KW_LEN[i]), ~seed), "long form");
		end
		check("clean decode flag", 9'h000, 9'(statusByte[3]));
		check("response flag", 9'h001, 9'(statusByte[4]));
		respTaken = 1'b1;
		@(posedge ref_clk);
		#1;
		respTaken = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check("response flag cleared", 9'h000, 9'(statusByte[4]));
		// Truncations between the two forms are refused and queue errors.
		k = 0;
		for (int i = 0; i < 14; i++) begin
			if (int'(scpi_pkg::KW_LEN[i]) > short_len(i) + 1) begin
				ex(5'h00, 4'h1, ERRM);
				run(spell(i, short_len(i) + 1, seed), "between forms");
				k++;
			end
		end
		for (int j = 0; j < k; j++) begin
			check("error flag held", 9'h001, 9'(statusByte[3]));
			pop_err();
		end
		check("error flag cleared", 9'h000, 9'(statusByte[3]));
		ex(5'h14, 4'h8, FULL);
		ex(5'h15, 4'h2, FULL);
		run("STAT:OPER:COND?;ENAB 16", "level kept");
		ex(5'h12, 4'h8, FULL);
		ex(5'h13, 4'h8, FULL);
		run("meas:volt?;curr?", "sibling query");
		ex(5'h12, 4'h8, FULL);
		ex(5'h0D, 4'h8, FULL);
		run("MEAS:VOLT?;:CURR?", "root colon");
		ex(5'h17, 4'h2, FULL);
		run(":SOUR:VOLT:LEV 6", "explicit source");
		ex(5'h12, 4'h8, FULL);
		run("MEAS:VOLT?", "first message");
		ex(5'h0D, 4'h8, FULL);
		run("CURR?", "after terminator");
		ex(5'h17, 4'h2, FULL);
		ex(5'h00, 4'h1, ERRM);
		run("VOLT:LEV 6;CURR:LEV 15;OUTP ON", "missing root");
		pop_err();
		ex(5'h19, 4'h8, FULL);
		run("SYST:ERR?", "resume after error");
		ex(5'h12, 4'h8, FULL);
		ex(5'h00, 4'h4, COMM);
		ex(5'h13, 4'h8, FULL);
		run("MEAS:VOLT?;*OPC;CURR?", "common command");
		ex(5'h00, 4'h1, ERRM);
		run("VOLT\r", "carriage return");
		pop_err();
		// Consumer stalls while five units arrive; the parser must refuse, not drop.
		holdOff = 1'b1;
		fork
			begin
				repeat (60) @(posedge ref_clk);
				#3;
				holdOff = 1'b0;
			end
		join_none
		for (int i = 10; i >= 6; i--) ex(5'(i + 1), 4'h0, FULL);
		run("TRIG;SYST;STAT;SOUR;OUTP", "stalled consumer");
		check("refusal seen", 9'h001, 9'(sawFull));
		close_out();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		repeat (60000) @(posedge ref_clk);
		errors++;
		$display("[ERR] watchdog expected finish seen timeout");
		close_out();
	end
endmodule
